//--- rtl/standby_regs.svh
`ifndef STANDBY_REGS_SVH
`define STANDBY_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SB_CTRL_OFS       8'h00
`define SB_STAB_SEL_OFS   8'h04
`define SB_STAB_STAT_OFS  8'h08
`define SB_STATUS_OFS     8'h0C

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define SB_CTRL_SRC_LSB   0
`define SB_CTRL_SRC_MSB   1
`define SB_CTRL_LSO_KEEP  2
`define SB_CTRL_HSX_ON    3
`define SB_CTRL_HOCO_ON   4
`define SB_CTRL_SUB_ON    5

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define SB_STAT_MODE_LSB  0
`define SB_STAT_MODE_MSB  1
`define SB_STAT_REFUSED   2
`define SB_STAT_SETTLING  3
`define SB_STAT_PENDING   4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SB_SRC_RESET      2'h0
`define SB_LSO_KEEP_RESET 1'h1
`define SB_HSX_ON_RESET   1'h0
`define SB_HOCO_ON_RESET  1'h1
`define SB_SUB_ON_RESET   1'h0
`define SB_STAB_SEL_RESET 3'h7

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SB_STAB_BASE_CYCLES 256
`define SB_STAB_CNT_W       16

`endif

//--- rtl/standby_pkg.sv
package standby_pkg;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_HALT,
        MODE_STOP,
        MODE_SETTLE
    } mode_t;

    // Clock source of the CPU
    typedef enum logic [1:0] {
        SRC_HOCO,
        SRC_CRYSTAL,
        SRC_EXT,
        SRC_SUB
    } clk_src_t;

    typedef struct packed {
        logic hsx;
        logic hoco;
        logic sub;
        logic lso;
    } osc_en_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        mode_t       mode;
        clk_src_t    clk_src;
        logic        lso_keep;
        logic        hsx_on;
        logic        hoco_on;
        logic        sub_on;
        logic [2:0]  stab_sel;
        logic        refused;
        logic        timer_start;
        logic        wake;
        osc_en_t     osc;
        logic [31:0] rdata;
    } ctl_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        busy;
        logic        done;
    } timer_state_t;

endpackage : standby_pkg

//--- rtl/osc_settle_timer.sv
`timescale 1ns/10ps
`include "standby_regs.svh"

module osc_settle_timer #(
    parameter int unsigned BASE_CYCLES = `SB_STAB_BASE_CYCLES
) (
    input  wire logic        clk,    // System clock
    input  wire logic        rst,    // Synchronous reset
    input  wire logic        start,  // Begin a settling wait
    input  wire logic [2:0]  sel,    // Wait length select
    output logic             busy,   // Wait in progress
    output logic             done,   // Wait over, one cycle
    output logic [15:0]      count   // Cycles still to go
);

    standby_pkg::timer_state_t st;
    standby_pkg::timer_state_t next_st;

    // Wait of BASE_CYCLES doubled sel times
    function automatic logic [15:0] stab_cycles(input logic [2:0] s);
        logic [31:0] c;
        c = BASE_CYCLES << s;
        return c[15:0];
    endfunction : stab_cycles

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (start) begin
            next_st.cnt  = stab_cycles(sel) - 16'h0001;
            next_st.busy = 1'b1;
        end else if (st.busy) begin
            if (st.cnt == 16'h0000) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy  = st.busy;
    assign done  = st.done;
    assign count = st.cnt;

endmodule : osc_settle_timer

//--- rtl/standby_mode_controller.sv
`timescale 1ns/10ps
`include "standby_regs.svh"

// Summary of operation
// [RL1] A halt instruction puts the block in halt and gates the CPU clock.
// [RL2] In halt every oscillator but the low-speed one keeps running as it was.
// [RL3] A stop instruction stops both high-speed oscillators.
// [RL4] Any unmasked interrupt request ends stop mode.
// [RL5] Leaving stop on the crystal clock waits out a settling time first.
// [RL6] Registers, flags and memory are frozen through both standby modes.
// [RL7] Port latches and output buffers are frozen through both modes.
// [RL8] Software stops main-clock peripherals before issuing stop.
// [RL9] Software never issues stop while running from the subsystem clock.
// [RL10] Software should clear the converter start and enable bits first.
// [RL11] The low-speed oscillator runs or stops in standby by a setting.
// [RL12] Halt is accepted whatever clock the CPU is running from.
// [RL13] Halt is not entered while an unmasked request is already pending.
// [RL14] An unmasked interrupt request ends halt mode.
// [RL15] On wake the CPU clock restarts and the CPU carries on.
module standby_mode_controller #(
    parameter int unsigned STAB_BASE_CYCLES = `SB_STAB_BASE_CYCLES
) (
    input  wire logic        clk,          // System clock, 100 MHz
    input  wire logic        rst,          // Synchronous reset
    input  wire logic [7:0]  reg_addr,     // Register byte address
    input  wire logic [31:0] reg_wdata,    // Register write data
    input  wire logic        reg_wr,       // Register write strobe
    input  wire logic        reg_rd,       // Register read strobe
    output logic      [31:0] reg_rdata,    // Read data, cycle after read
    input  wire logic        halt_exec,    // CPU executes halt
    input  wire logic        stop_exec,    // CPU executes stop
    input  wire logic [31:0] irq_req,      // Interrupt request flags
    input  wire logic [31:0] irq_mask,     // Interrupt mask flags, 1 masks
    output logic             cpu_clk_en,   // CPU clock enable
    output logic             hold_state,   // Freeze regs, memory, ports
    output logic             wake,         // Standby ended, one cycle
    output logic             hsx_osc_en,   // High-speed crystal oscillator
    output logic             hoco_osc_en,  // High-speed on-chip oscillator
    output logic             sub_osc_en,   // Subsystem oscillator
    output logic             lso_osc_en    // Low-speed on-chip oscillator
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    standby_pkg::ctl_state_t st;
    standby_pkg::ctl_state_t next_st;
    standby_pkg::reg_req_t   req;

    logic        pending;
    logic        tmr_busy;
    logic        tmr_done;
    logic [15:0] tmr_count;

    assign req = '{addr: reg_addr, wdata: reg_wdata,
                   wr: reg_wr, rd: reg_rd};

    function automatic logic irq_pending(input logic [31:0] r,
                                         input logic [31:0] m);
        return |(r & ~m);
    endfunction : irq_pending

    function automatic standby_pkg::osc_en_t osc_for(
        input standby_pkg::mode_t m,
        input logic hsx_on,
        input logic hoco_on,
        input logic sub_on,
        input logic lso_keep);
        standby_pkg::osc_en_t o;
        o.hsx  = hsx_on;
        o.hoco = hoco_on;
        o.sub  = sub_on;
        o.lso  = 1'b1;
        if (m == standby_pkg::MODE_STOP) begin
            o.hsx  = 1'b0; // RL3
            o.hoco = 1'b0; // RL3
        end
        if (m != standby_pkg::MODE_RUN) begin
            o.lso = lso_keep; // RL11
        end
        return o;
    endfunction : osc_for

    assign pending = irq_pending(irq_req, irq_mask);

    // ------------------------------------------------------------
    // Oscillator settling timer
    // ------------------------------------------------------------
    osc_settle_timer #(
        .BASE_CYCLES (STAB_BASE_CYCLES)
    ) u_settle (
        .clk   (clk),
        .rst   (rst),
        .start (st.timer_start),
        .sel   (st.stab_sel),
        .busy  (tmr_busy),
        .done  (tmr_done),
        .count (tmr_count)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic set_refused;
        logic clr_refused;
        set_refused         = 1'b0;
        clr_refused         = 1'b0;
        next_st             = st;
        next_st.timer_start = 1'b0;
        next_st.wake        = 1'b0;
        next_st.rdata       = 32'h0000_0000;

        case (st.mode)
            standby_pkg::MODE_RUN: begin
                // Accepted from any CPU clock source
                if (halt_exec) begin // RL12
                    if (pending) begin
                        set_refused = 1'b1; // RL13
                    end else begin
                        next_st.mode = standby_pkg::MODE_HALT; // RL1
                    end
                end else if (stop_exec) begin
                    // A request already waiting would end stop at
                    // once, so stop is refused the same way as halt
                    if (pending) begin
                        set_refused = 1'b1;
                    end else begin
                        next_st.mode = standby_pkg::MODE_STOP; // RL3
                    end
                end
            end
            standby_pkg::MODE_HALT: begin
                if (pending) begin // RL14
                    next_st.mode = standby_pkg::MODE_RUN;
                    next_st.wake = 1'b1; // RL15
                end
            end
            standby_pkg::MODE_STOP: begin
                if (pending) begin // RL4
                    if (st.clk_src == standby_pkg::SRC_CRYSTAL) begin
                        next_st.mode        = standby_pkg::MODE_SETTLE;
                        next_st.timer_start = 1'b1; // RL5
                    end else begin
                        next_st.mode = standby_pkg::MODE_RUN;
                        next_st.wake = 1'b1; // RL15
                    end
                end
            end
            standby_pkg::MODE_SETTLE: begin
                // The request that woke us is already latched by the
                // interrupt logic, so it need not stay high here
                if (tmr_done) begin // RL5
                    next_st.mode = standby_pkg::MODE_RUN;
                    next_st.wake = 1'b1; // RL15
                end
            end
            default: begin
                next_st.mode = standby_pkg::MODE_RUN;
            end
        endcase

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        // Clock setup writes are taken in every mode; the CPU cannot
        // issue bus cycles in standby anyway.
        if (req.wr) begin
            case (req.addr)
                `SB_CTRL_OFS: begin
                    next_st.clk_src = standby_pkg::clk_src_t'(
                        req.wdata[`SB_CTRL_SRC_MSB:`SB_CTRL_SRC_LSB]);
                    next_st.lso_keep = req.wdata[`SB_CTRL_LSO_KEEP];
                    next_st.hsx_on   = req.wdata[`SB_CTRL_HSX_ON];
                    next_st.hoco_on  = req.wdata[`SB_CTRL_HOCO_ON];
                    next_st.sub_on   = req.wdata[`SB_CTRL_SUB_ON];
                end
                `SB_STAB_SEL_OFS: begin
                    next_st.stab_sel = req.wdata[2:0];
                end
                `SB_STATUS_OFS: begin
                    clr_refused = req.wdata[`SB_STAT_REFUSED];
                end
                default: begin
                end
            endcase
        end

        // A refusal in the same cycle as its clear is kept
        next_st.refused = (st.refused & ~clr_refused) | set_refused;

        // --------------------------------------------------------
        // Register reads
        // --------------------------------------------------------
        if (req.rd) begin
            case (req.addr)
                `SB_CTRL_OFS: begin
                    next_st.rdata[`SB_CTRL_SRC_MSB:`SB_CTRL_SRC_LSB] =
                        st.clk_src;
                    next_st.rdata[`SB_CTRL_LSO_KEEP] = st.lso_keep;
                    next_st.rdata[`SB_CTRL_HSX_ON]   = st.hsx_on;
                    next_st.rdata[`SB_CTRL_HOCO_ON]  = st.hoco_on;
                    next_st.rdata[`SB_CTRL_SUB_ON]   = st.sub_on;
                end
                `SB_STAB_SEL_OFS: begin
                    next_st.rdata[2:0] = st.stab_sel;
                end
                `SB_STAB_STAT_OFS: begin
                    next_st.rdata[15:0] = tmr_count;
                end
                `SB_STATUS_OFS: begin
                    next_st.rdata[`SB_STAT_MODE_MSB:`SB_STAT_MODE_LSB] =
                        st.mode;
                    next_st.rdata[`SB_STAT_REFUSED]  = st.refused;
                    next_st.rdata[`SB_STAT_SETTLING] = tmr_busy;
                    next_st.rdata[`SB_STAT_PENDING]  = pending;
                end
                default: begin
                end
            endcase
        end

        // Halt keeps all but the low-speed osc as it was; stop drops the fast pair
        next_st.osc = osc_for(next_st.mode, next_st.hsx_on,
                              next_st.hoco_on, next_st.sub_on,
                              next_st.lso_keep); // RL2
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st.mode        <= standby_pkg::MODE_RUN;
            st.clk_src     <= standby_pkg::clk_src_t'(`SB_SRC_RESET);
            st.lso_keep    <= `SB_LSO_KEEP_RESET;
            st.hsx_on      <= `SB_HSX_ON_RESET;
            st.hoco_on     <= `SB_HOCO_ON_RESET;
            st.sub_on      <= `SB_SUB_ON_RESET;
            st.stab_sel    <= `SB_STAB_SEL_RESET;
            st.refused     <= 1'b0;
            st.timer_start <= 1'b0;
            st.wake        <= 1'b0;
            st.osc         <= '{hsx: `SB_HSX_ON_RESET,
                                hoco: `SB_HOCO_ON_RESET,
                                sub: `SB_SUB_ON_RESET, lso: 1'b1};
            st.rdata       <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The freeze covers settling too: the CPU must not see a clock
    // until the crystal is stable.
    assign cpu_clk_en  = (st.mode == standby_pkg::MODE_RUN); // RL15
    assign hold_state  = (st.mode != standby_pkg::MODE_RUN); // RL6 RL7
    assign wake        = st.wake;
    assign hsx_osc_en  = st.osc.hsx;
    assign hoco_osc_en = st.osc.hoco;
    assign sub_osc_en  = st.osc.sub;
    assign lso_osc_en  = st.osc.lso;
    assign reg_rdata   = st.rdata;

endmodule : standby_mode_controller

//--- tb/standby_checker.sv
`timescale 1ns/10ps
`include "standby_regs.svh"

module standby_checker #(
    parameter int unsigned STAB_BASE_CYCLES = 256
) (
    input wire logic        clk,         // Clock
    input wire logic        rst,         // Reset
    input wire logic [7:0]  reg_addr,    // Address
    input wire logic [31:0] reg_wdata,   // Write data
    input wire logic        reg_wr,      // Write strobe
    input wire logic        halt_exec,   // Halt
    input wire logic        stop_exec,   // Stop
    input wire logic [31:0] irq_req,     // Requests
    input wire logic [31:0] irq_mask,    // Masks
    input wire logic        cpu_clk_en,  // CPU clock
    input wire logic        hold_state,  // Freeze
    input wire logic        wake,        // Wake pulse
    input wire logic        hsx_osc_en,  // Crystal osc
    input wire logic        hoco_osc_en, // On-chip osc
    input wire logic        sub_osc_en,  // Sub osc
    input wire logic        lso_osc_en   // Low-speed osc
);
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    logic pending;
    logic lso_keep;

    assign pending = |(irq_req & ~irq_mask);

    // Shadow of the keep bit, so the check needs no peek inside
    always_ff @(posedge clk) begin
        if (rst) begin
            lso_keep <= 1'b1;
        end else if (reg_wr && reg_addr == `SB_CTRL_OFS) begin
            lso_keep <= reg_wdata[`SB_CTRL_LSO_KEEP];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence halt_taken;
        halt_exec && cpu_clk_en && !pending;
    endsequence
    sequence stop_taken;
        stop_exec && !halt_exec && cpu_clk_en && !pending;
    endsequence
    sequence settle_start;
        hold_state && $rose(hsx_osc_en);
    endsequence

    a_halt_gates_clk: assert property (halt_taken |=> hold_state && !cpu_clk_en)
        else $error("halt did not gate the CPU clock");
    a_halt_keeps_osc: assert property (halt_taken |=> $stable(hsx_osc_en) && $stable(hoco_osc_en) && $stable(sub_osc_en))
        else $error("oscillator changed on halt");
    a_stop_drops_hs: assert property (stop_taken |=> hold_state && !hsx_osc_en && !hoco_osc_en)
        else $error("stop left a fast oscillator on");
    a_wake_on_irq: assert property (hold_state && pending |-> ##[1:600] wake)
        else $error("no wake after request");
    a_settle_waits: assert property (settle_start |-> (hold_state && !wake)[*8] ##[1:600] wake)
        else $error("settling wait cut short");
    a_hold_no_clk: assert property (hold_state |-> !cpu_clk_en)
        else $error("CPU clocked while frozen");
    a_lso_setting: assert property (hold_state |-> lso_osc_en == lso_keep)
        else $error("low-speed osc ignores setting");
    a_refuse_pending: assert property ((halt_exec || stop_exec) && cpu_clk_en && pending |=> cpu_clk_en && !hold_state)
        else $error("standby entered with request pending");
    a_wake_restart: assert property (wake |-> cpu_clk_en && !hold_state && $past(hold_state))
        else $error("wake without clock restart");
endmodule : standby_checker

//--- tb/cpu_irq_model.sv
`timescale 1ns/10ps

module cpu_irq_model (
    input  wire logic        clk,        // Clock
    input  wire logic        cpu_clk_en, // CPU clock enable
    output logic             halt_exec,  // Halt pulse
    output logic             stop_exec,  // Stop pulse
    output logic      [31:0] irq_req,    // Request flags
    output logic      [31:0] irq_mask    // Mask flags
);
    // ----------------------------------------
    // CPU and interrupt flags
    // ----------------------------------------
    initial begin
        halt_exec = 1'b0;
        stop_exec = 1'b0;
        irq_req = 32'h0;
        irq_mask = 32'hFFFFFFFF;
    end

    // A gated CPU fetches nothing, so it waits for its clock
    task automatic run_insn(input logic is_stop,
                            input standby_pkg::clk_src_t src);
        @(posedge clk);
        while (cpu_clk_en !== 1'b1) @(posedge clk);
        if (is_stop && src == standby_pkg::SRC_SUB) return;
        // Main-clock peripherals and converter already idle here
        stop_exec <= is_stop;
        halt_exec <= !is_stop;
        @(posedge clk);
        halt_exec <= 1'b0;
        stop_exec <= 1'b0;
    endtask : run_insn

    task automatic set_irq(input int unsigned idx, input logic masked);
        @(posedge clk);
        irq_req[idx] <= 1'b1;
        irq_mask[idx] <= masked;
    endtask : set_irq

    task automatic clear_irq();
        @(posedge clk);
        irq_req <= 32'h0;
        irq_mask <= 32'hFFFFFFFF;
    endtask : clear_irq
endmodule : cpu_irq_model

//--- tb/tb_top.sv
`timescale 1ns/10ps
`include "standby_regs.svh"

module tb_top;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic        clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        halt_exec;
    logic        stop_exec;
    logic [31:0] irq_req;
    logic [31:0] irq_mask;
    logic        cpu_clk_en;
    logic        hold_state;
    logic        wake;
    logic        hsx_osc_en;
    logic        hoco_osc_en;
    logic        sub_osc_en;
    logic        lso_osc_en;
    int          num_errors;
    int          total_checks;
    int          cycles;
    int          waited;
    standby_pkg::clk_src_t src;

    standby_mode_controller #(.STAB_BASE_CYCLES(4)) DUT (
        .clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .halt_exec(halt_exec),
        .stop_exec(stop_exec), .irq_req(irq_req), .irq_mask(irq_mask),
        .cpu_clk_en(cpu_clk_en), .hold_state(hold_state), .wake(wake),
        .hsx_osc_en(hsx_osc_en), .hoco_osc_en(hoco_osc_en),
        .sub_osc_en(sub_osc_en), .lso_osc_en(lso_osc_en)
    );

    cpu_irq_model cpu (
        .clk(clk), .cpu_clk_en(cpu_clk_en), .halt_exec(halt_exec),
        .stop_exec(stop_exec), .irq_req(irq_req), .irq_mask(irq_mask)
    );

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] pins();
        return {26'h0, cpu_clk_en, hold_state, hsx_osc_en, hoco_osc_en,
                sub_osc_en, lso_osc_en};
    endfunction : pins

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
        // Read data stand for one cycle only, then return to zero
        @(posedge clk);
        #1;
        check(reg_rdata, 32'h0);
    endtask : reg_read

    // Bounded so a lost wake ends as a mismatch, not a hang
    task automatic wait_wake();
        waited = 0;
        #1;
        while (wake !== 1'b1 && waited < 1000) begin
            @(posedge clk);
            #1;
            waited++;
        end
        check({29'h0, wake, cpu_clk_en, hold_state}, 32'h6);
    endtask : wait_wake

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(pins(), 32'h25);
        reg_read(`SB_CTRL_OFS, 32'h14);
        reg_read(`SB_STAB_SEL_OFS, 32'h7);
        reg_read(`SB_STATUS_OFS, 32'h0);
        reg_write(8'h40, 32'hFFFFFFFF);
        reg_read(8'h40, 32'h0);
        for (int s = 0; s < 4; s++) begin
            src = standby_pkg::clk_src_t'(s);
            reg_write(`SB_CTRL_OFS, 32'h3C | 32'(s));
            cpu.run_insn(1'b0, src);
            #1;
            check(pins(), 32'h1F);
            reg_read(`SB_STATUS_OFS, 32'h1);
            cpu.set_irq(s, 1'b0);
            wait_wake();
            cpu.clear_irq();
        end
        // Unmasked request blocks entry, a masked one does not
        cpu.set_irq(3, 1'b0);
        cpu.run_insn(1'b0, src);
        #1;
        check(pins(), 32'h2F);
        reg_read(`SB_STATUS_OFS, 32'h14);
        cpu.set_irq(3, 1'b1);
        cpu.run_insn(1'b0, src);
        #1;
        check(pins(), 32'h1F);
        cpu.set_irq(3, 1'b0);
        wait_wake();
        cpu.clear_irq();
        reg_write(`SB_STATUS_OFS, 32'h4);
        reg_read(`SB_STATUS_OFS, 32'h0);
        reg_write(`SB_CTRL_OFS, 32'h38);
        cpu.run_insn(1'b1, standby_pkg::SRC_HOCO);
        #1;
        check(pins(), 32'h12);
        reg_read(`SB_STATUS_OFS, 32'h2);
        cpu.set_irq(5, 1'b0);
        wait_wake();
        check(pins(), 32'h2F);
        cpu.clear_irq();
        reg_write(`SB_STAB_SEL_OFS, 32'h1);
        reg_write(`SB_CTRL_OFS, 32'h3D);
        cpu.run_insn(1'b1, standby_pkg::SRC_CRYSTAL);
        #1;
        check(pins(), 32'h13);
        cpu.set_irq(7, 1'b0);
        wait_wake();
        check({31'h0, waited >= 8}, 32'h1);
        reg_read(`SB_STAB_STAT_OFS, 32'h0);
        reg_read(`SB_STATUS_OFS, 32'h10);
        cpu.clear_irq();
        report_and_stop();
    end
endmodule : tb_top

bind standby_mode_controller standby_checker #(
    .STAB_BASE_CYCLES(STAB_BASE_CYCLES)
) u_checker (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .halt_exec(halt_exec), .stop_exec(stop_exec),
    .irq_req(irq_req), .irq_mask(irq_mask), .cpu_clk_en(cpu_clk_en),
    .hold_state(hold_state), .wake(wake), .hsx_osc_en(hsx_osc_en),
    .hoco_osc_en(hoco_osc_en), .sub_osc_en(sub_osc_en),
    .lso_osc_en(lso_osc_en)
);
